// ==== common/adcc_pkg.sv ====
// Shared constants, register map and types of the converter control block.
`default_nettype none
package adcc_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets on the APB bus.
  // ---------------------------------------------------------------
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;     // Channel select.
  localparam logic [7:0] OFF_CFG = 8'h04;      // Mode and compare setup.
  localparam logic [7:0] OFF_STATUS = 8'h08;   // Sticky events, write one to clear.
  localparam logic [7:0] OFF_MASK = 8'h0c;     // Interrupt enables.
  localparam logic [7:0] OFF_RES_HI = 8'h10;   // Result high register.
  localparam logic [7:0] OFF_RES_LO = 8'h14;   // Result low register.
  localparam logic [7:0] OFF_COMPARE = 8'h18;  // Compare value.
  localparam logic [7:0] OFF_PIN_DIS = 8'h1c;  // Upper pin control register.
  // ---------------------------------------------------------------
  // Field positions and special channel codes.
  // ---------------------------------------------------------------
  localparam int unsigned CH_W = 5;
  localparam logic [4:0] CH_OFF = 5'h1f;       // All ones switches the converter off.
  localparam logic [4:0] TEMP_CH = 5'h1a;      // Internal temperature sensor.
  localparam logic [4:0] BANDGAP_CH = 5'h1b;   // Internal bandgap reference.
  localparam int unsigned CFG_CMP_EN_BIT = 2;
  localparam int unsigned CFG_CMP_GE_BIT = 3;
  localparam int unsigned ST_DONE_BIT = 0;
  localparam int unsigned ST_CMP_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 2;
  localparam logic [3:0] RAW_BITS_WIDE = 4'hc;
  localparam logic [3:0] RAW_BITS_NARROW = 4'h9;
  // ---------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------
  localparam logic [4:0] CTRL_RST = 5'h1f;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [11:0] CMP_RST = 12'h000;
  localparam logic [7:0] PIN_RST = 8'h00;
  // ---------------------------------------------------------------
  // Timing: comparator settle time per approximation step.
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SETTLE_PS = 15000;
  localparam int unsigned SETTLE_CYC = (SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ---------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_8 = 2'h0,
    MODE_12 = 2'h1,
    MODE_10 = 2'h2
  } adcc_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_STORE = 3'b100
  } adcc_state_t;
endpackage
`default_nettype wire

// ==== logic/adcc_sar.sv ====
// Successive approximation sequencer: one trial bit per settle period.
`default_nettype none
module adcc_sar
  import adcc_pkg::*;
#(
  parameter int unsigned W = 12,
  parameter int unsigned SETTLE = SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] nbits,
  input wire logic cmp_hi,
  output logic [W-1:0] trial,
  output logic [W-1:0] result,
  output logic done,
  output logic busy
);
  // ---------------------------------------------------------------
  // Elaboration checks.
  // ---------------------------------------------------------------
  if (W < 9 || W > 15 || SETTLE < 1 || SETTLE > 255) begin : g_bad
    $error("adcc_sar: unsupported width or settle count");
  end

  // ---------------------------------------------------------------
  // Step decode.
  // ---------------------------------------------------------------
  logic [3:0] idx;        // Bit under trial.
  logic [7:0] wcnt;       // Settle counter.
  logic [3:0] nb_q;       // Raw width of the running conversion.
  // Trials run from the top bit down, so a short result stays left aligned on the DAC.
  // That way a nine-bit conversion still spans the full input range.
  wire [3:0] stop_idx = 4'(W) - nb_q;
  wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] bit_mask = one << idx;
  wire last_wait = (wcnt == 8'(SETTLE - 1));
  // Keep the trial bit only if the input is at or above the trial level.
  wire [W-1:0] decided = cmp_hi ? trial : (trial & ~bit_mask);

  // The settle count must cover the two-stage comparator synchroniser.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      idx <= 4'h0;
      wcnt <= 8'h00;
      trial <= '0;
      result <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        idx <= 4'(W - 1);
        wcnt <= 8'h00;
        trial <= {1'b1, {(W-1){1'b0}}};
      end else if (abort) begin
        // Parking the DAC code at zero keeps the array quiet.
        busy <= 1'b0;
        trial <= '0;
      end else if (busy && !last_wait) begin
        wcnt <= wcnt + 8'h01;
      end else if (busy) begin
        wcnt <= 8'h00;
        if (idx == stop_idx) begin
          busy <= 1'b0;
          done <= 1'b1;
          // The result leaves right justified, whatever its width.
          result <= decided >> stop_idx;
          trial <= '0;
        end else begin
          idx <= idx - 4'h1;
          trial <= decided | (bit_mask >> 1);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks: conversion length follows the raw width.
  // ---------------------------------------------------------------
  logic [15:0] cyc;       // Edges since start.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 16'h0000;
      nb_q <= 4'h0;
    end else if (start) begin
      cyc <= 16'h0000;
      nb_q <= nbits;
    end else if (busy) begin
      cyc <= cyc + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_len;
    done |-> (cyc == 16'(nb_q * SETTLE)) && (nb_q == RAW_BITS_WIDE || nb_q == RAW_BITS_NARROW);
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong"); // [RQ3] [RQ4]
endmodule
`default_nettype wire

// ==== logic/adcc_top.sv ====
// Converter control: APB registers, conversion sequencing, result placement.
// What this block does
// RQ1 - Off during reset or all-ones channel select.
// RQ2 - Idle at lowest power between conversions.
// RQ3 - Twelve- and ten-bit modes make twelve raw bits.
// RQ4 - Eight-bit mode makes nine raw bits.
// RQ5 - Ten-bit mode rounds, fills high and low.
// RQ6 - Eight-bit mode rounds, fills low only.
// RQ7 - Set done flag after store; interrupt if enabled.
// RQ8 - Compare enabled checks every result against compare.
// RQ9 - Upper pin bits disable I/O of channels 16-23.
// RQ10 - Temperature sensor sits on channel 26.
// RQ11 - Bandgap reference sits on channel 27.
// RQ12 - Software uses long sample, slow clock for sensor.
// RQ13 - Writing a live channel starts a conversion.
`default_nettype none
module adcc_top
  import adcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_in,
  output logic [11:0] sar_trial,
  output logic [4:0] mux_sel,
  output logic analog_en,
  output logic temp_sensor_en,
  output logic bandgap_en,
  output logic [7:0] pin_io_disable,
  output logic irq
);
  // ---------------------------------------------------------------
  // Reset release and comparator synchroniser.
  // ---------------------------------------------------------------
  logic [1:0] rst_sync;   // Reset release pipeline.
  logic cmp_meta;         // First stage, read only by cmp_hi.
  logic cmp_hi;           // Comparator level, safe to use.
  wire rst_n = rst_sync[1];

  // Reset asserts at once and releases two edges later.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // The comparator is asynchronous to this clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_meta <= 1'b0;
      cmp_hi <= 1'b0;
    end else begin
      cmp_meta <= cmp_in;
      cmp_hi <= cmp_meta;
    end
  end

  // ---------------------------------------------------------------
  // Registers and bus decode.
  // ---------------------------------------------------------------
  logic [3:0] cfg;            // Mode, compare enable, compare sense.
  logic [2:0] status;         // Busy, compare hit, done.
  logic [1:0] mask;           // Bit 0 is the done interrupt enable.
  logic [7:0] result_high;    // Result high register.
  logic [7:0] result_low;     // Result low register.
  logic [11:0] compare;       // Compare value.
  adcc_state_t state;         // Sequencer state.
  adcc_state_t next_state;    // Next sequencer state.
  adcc_mode_t conv_mode;      // Mode latched at conversion start.
  logic conv_cmp_en;          // Compare enable latched at start.

  wire setup = psel && !penable;
  wire acc_we = psel && penable && pready && pwrite;
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_cfg = (paddr == OFF_CFG);
  wire hit_status = (paddr == OFF_STATUS);
  wire hit_mask = (paddr == OFF_MASK);
  wire hit_hi = (paddr == OFF_RES_HI);
  wire hit_lo = (paddr == OFF_RES_LO);
  wire hit_cmp = (paddr == OFF_COMPARE);
  wire hit_pin = (paddr == OFF_PIN_DIS);
  wire mapped = hit_ctrl || hit_cfg || hit_status || hit_mask || hit_hi || hit_lo
    || hit_cmp || hit_pin;
  wire wr_ctrl = acc_we && hit_ctrl;
  wire wr_pin = acc_we && hit_pin;
  // A live channel write starts, an all-ones write stops.
  wire start = wr_ctrl && (pwdata[4:0] != CH_OFF);
  wire abort = wr_ctrl && (pwdata[4:0] == CH_OFF);
  wire [4:0] next_mux = wr_ctrl ? pwdata[4:0] : mux_sel;
  wire [1:0] w1c = (acc_we && hit_status) ? pwdata[1:0] : 2'b00;

  // Read multiplexer; unused bits read as zero.
  wire [31:0] rd_mux =
    hit_ctrl ? {27'h0, mux_sel} :
    hit_cfg ? {28'h0, cfg} :
    hit_status ? {29'h0, status} :
    hit_mask ? {30'h0, mask} :
    hit_hi ? {24'h0, result_high} :
    hit_lo ? {24'h0, result_low} :
    hit_cmp ? {20'h0, compare} :
    hit_pin ? {24'h0, pin_io_disable} : 32'h0;

  // Ready rises for the first access cycle, so every transfer has no wait.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= setup ? rd_mux : 32'h0;
      pslverr <= setup && !mapped;
    end
  end

  // Plain software registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_sel <= CTRL_RST;
      cfg <= CFG_RST;
      mask <= MASK_RST;
      compare <= CMP_RST;
      pin_io_disable <= PIN_RST;
    end else begin
      mux_sel <= next_mux;
      if (acc_we && hit_cfg) cfg <= pwdata[3:0];
      if (acc_we && hit_mask) mask <= pwdata[1:0];
      if (acc_we && hit_cmp) compare <= pwdata[11:0];
      if (wr_pin) pin_io_disable <= pwdata[7:0]; // [RQ9]
    end
  end

  // ---------------------------------------------------------------
  // Approximation engine.
  // ---------------------------------------------------------------
  wire [3:0] eng_nbits = (adcc_mode_t'(cfg[1:0]) == MODE_8) ? RAW_BITS_NARROW :
    RAW_BITS_WIDE; // [RQ3] [RQ4]
  wire [11:0] eng_result;
  wire eng_done;
  wire eng_busy;

  adcc_sar #(
    .W(12),
    .SETTLE(SETTLE_CYC)
  ) adcc_sar_i (
    .clk(clk),
    .rst_n(rst_n),
    .start(start),
    .abort(abort),
    .nbits(eng_nbits),
    .cmp_hi(cmp_hi),
    .trial(sar_trial),
    .result(eng_result),
    .done(eng_done),
    .busy(eng_busy)
  );

  // ---------------------------------------------------------------
  // Rounding and placement.
  // ---------------------------------------------------------------
  // Rounding saturates at full scale rather than wrapping to zero.
  wire [12:0] sum10 = {1'b0, eng_result} + 13'h0002;
  wire [9:0] r10 = sum10[12] ? 10'h3ff : sum10[11:2]; // [RQ5]
  wire [9:0] sum8 = {1'b0, eng_result[8:0]} + 10'h001;
  wire [7:0] r8 = sum8[9] ? 8'hff : sum8[8:1]; // [RQ6]
  wire [7:0] next_hi = (conv_mode == MODE_10) ? {6'h00, r10[9:8]} :
    (conv_mode == MODE_8) ? 8'h00 : {4'h0, eng_result[11:8]};
  wire [7:0] next_lo = (conv_mode == MODE_10) ? r10[7:0] :
    (conv_mode == MODE_8) ? r8 : eng_result[7:0];
  wire store = (state == ST_CONV) && eng_done;
  wire [11:0] stored_val = {result_high[3:0], result_low};
  wire cmp_ge = stored_val >= compare;
  wire cmp_hit = cfg[CFG_CMP_GE_BIT] ? cmp_ge : !cmp_ge;

  // Result registers change only when a conversion ends.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_high <= 8'h00;
      result_low <= 8'h00;
    end else if (store) begin
      result_high <= next_hi; // [RQ5] [RQ6]
      result_low <= next_lo;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer.
  // ---------------------------------------------------------------
  // A channel write always wins, so a running conversion restarts cleanly.
  always_comb begin
    next_state = state;
    if (wr_ctrl) begin
      next_state = start ? ST_CONV : ST_IDLE; // [RQ1] [RQ13]
    end else begin
      unique case (state)
        ST_IDLE: next_state = ST_IDLE;
        ST_CONV: next_state = eng_done ? ST_STORE : ST_CONV; // [RQ3] [RQ4]
        ST_STORE: next_state = ST_IDLE; // [RQ2]
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Analog parts are powered only while converting; idle is the low power state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      conv_mode <= MODE_8;
      conv_cmp_en <= 1'b0;
      analog_en <= 1'b0;
      temp_sensor_en <= 1'b0;
      bandgap_en <= 1'b0;
    end else begin
      state <= next_state;
      if (start) conv_mode <= adcc_mode_t'(cfg[1:0]);
      if (start) conv_cmp_en <= cfg[CFG_CMP_EN_BIT];
      analog_en <= (next_state == ST_CONV); // [RQ1] [RQ2]
      temp_sensor_en <= (next_state == ST_CONV) && (next_mux == TEMP_CH); // [RQ10]
      bandgap_en <= (next_state == ST_CONV) && (next_mux == BANDGAP_CH); // [RQ11]
    end
  end

  // ---------------------------------------------------------------
  // Events and interrupt.
  // ---------------------------------------------------------------
  wire set_done = (state == ST_STORE); // [RQ7]
  wire set_cmp = (state == ST_STORE) && conv_cmp_en && cmp_hit; // [RQ8]

  // A new event beats a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 3'b000;
      irq <= 1'b0;
    end else begin
      status[ST_DONE_BIT] <= (status[ST_DONE_BIT] && !w1c[0]) || set_done;
      status[ST_CMP_BIT] <= (status[ST_CMP_BIT] && !w1c[1]) || set_cmp;
      status[ST_BUSY_BIT] <= (next_state == ST_CONV);
      irq <= |(status[1:0] & mask); // [RQ7]
    end
  end

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_off;
    (mux_sel == CH_OFF) |-> !analog_en && (state == ST_IDLE) && (sar_trial == 12'h000);
  endproperty
  a_off: assert property (p_off) else $error("converter active while off"); // [RQ1]
  property p_idle;
    (state == ST_STORE) && !wr_ctrl |=> (state == ST_IDLE) && !analog_en [*2];
  endproperty
  a_idle: assert property (p_idle) else $error("not idle after completion"); // [RQ2]
  property p_narrow;
    store && (conv_mode == MODE_8) |-> (eng_result[11:9] == 3'h0);
  endproperty
  a_narrow: assert property (p_narrow) else $error("eight-bit raw too wide"); // [RQ4]
  property p_ten;
    store && (conv_mode == MODE_10) |=> ({result_high, result_low} == {6'h00, $past(r10)});
  endproperty
  a_ten: assert property (p_ten) else $error("ten-bit result misplaced"); // [RQ5]
  property p_eight;
    store && (conv_mode == MODE_8) |=> (result_high == 8'h00) && (result_low == $past(r8));
  endproperty
  a_eight: assert property (p_eight) else $error("eight-bit result misplaced"); // [RQ6]
  property p_done;
    store && !wr_ctrl |=> ##1 status[ST_DONE_BIT] ##1 (irq == mask[0]);
  endproperty
  a_done: assert property (p_done) else $error("done flag or interrupt wrong"); // [RQ7]
  property p_cmp;
    set_cmp |=> status[ST_CMP_BIT] ##1 (irq == (mask[1] || (mask[0] && status[0])));
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare hit lost"); // [RQ8]
  property p_pin;
    wr_pin |=> (pin_io_disable == $past(pwdata[7:0]));
  endproperty
  a_pin: assert property (p_pin) else $error("pin control not written"); // [RQ9]
  property p_temp;
    temp_sensor_en == (analog_en && (mux_sel == TEMP_CH));
  endproperty
  a_temp: assert property (p_temp) else $error("temperature routing wrong"); // [RQ10]
  property p_bg;
    bandgap_en == (analog_en && (mux_sel == BANDGAP_CH));
  endproperty
  a_bg: assert property (p_bg) else $error("bandgap routing wrong"); // [RQ11]
  property p_start;
    start |=> (state == ST_CONV) && analog_en && (mux_sel == $past(pwdata[4:0]));
  endproperty
  a_start: assert property (p_start) else $error("write did not start"); // [RQ13]
endmodule
`default_nettype wire

// ==== tb/adcc_analog_model.sv ====
// Behavioural analog front end: channel levels and the comparator.
`default_nettype none
module adcc_analog_model
  import adcc_pkg::*;
#(
  parameter logic [11:0] TEMP_LVL = 12'h6c3,  // Plain sensor level for the bench.
  parameter logic [11:0] BG_LVL = 12'h4d2  // Plain reference level for the bench.
) (
  input wire logic clk,
  input wire logic [11:0] sar_trial,
  input wire logic [4:0] mux_sel,
  input wire logic analog_en,
  input wire logic temp_sensor_en,
  input wire logic bandgap_en,
  output logic cmp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Input level selection.
  // ------------------------------------------------------------
  // Internal sources appear only when their enable is raised, so a missing enable shows.
  logic [11:0] level;
  assign level = temp_sensor_en ? TEMP_LVL :
                 bandgap_en ? BG_LVL :
                 (mux_sel[3:0] == 4'hf) ? 12'hfff : {mux_sel[3:0], 8'h36};
  // ------------------------------------------------------------
  // Comparator.
  // ------------------------------------------------------------
  // The trial code is taken as left aligned and the comparator follows it at once.
  // Outside a conversion the output toggles, since nothing should trust it then.
  logic idle_tog;
  initial idle_tog = 1'b0;
  always @(posedge clk) begin
    idle_tog <= ~idle_tog;
  end
  assign cmp_in = analog_en ? (level >= sar_trial) : idle_tog;
endmodule
`default_nettype wire

// ==== tb/tb_adc_conversion_control.sv ====
// Self-checking bench for the converter control block.
`default_nettype none
module tb_adc_conversion_control
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals and bench state.
  // ------------------------------------------------------------
  localparam logic [11:0] T_LVL = 12'h6c3;  // Sensor level handed to the model.
  localparam logic [11:0] B_LVL = 12'h4d2;  // Reference level handed to the model.
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, cmp_in;
  logic analog_en, temp_sensor_en, bandgap_en, irq, err;
  logic [7:0] paddr, pin_io_disable;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] sar_trial;
  logic [4:0] mux_sel;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  adcc_top adcc_top_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_in(cmp_in), .sar_trial(sar_trial), .mux_sel(mux_sel),
    .analog_en(analog_en), .temp_sensor_en(temp_sensor_en), .bandgap_en(bandgap_en),
    .pin_io_disable(pin_io_disable), .irq(irq));
  adcc_analog_model #(.TEMP_LVL(T_LVL), .BG_LVL(B_LVL)) adcc_analog_model_i (.clk(clk),
    .sar_trial(sar_trial), .mux_sel(mux_sel), .analog_en(analog_en),
    .temp_sensor_en(temp_sensor_en), .bandgap_en(bandgap_en), .cmp_in(cmp_in));
  // Clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // Tasks.
  // ------------------------------------------------------------
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) chk("pready", pready, 1'b1);
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdreg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [11:0] lvl(input logic [4:0] ch);
    if (ch == TEMP_CH) return T_LVL;
    if (ch == BANDGAP_CH) return B_LVL;
    return (ch[3:0] == 4'hf) ? 12'hfff : {ch[3:0], 8'h36};
  endfunction
  // Rounded, saturated result as it should land in the result registers.
  function automatic logic [11:0] exp_res(input logic [4:0] ch, input adcc_mode_t m);
    logic [12:0] r;
    r = {1'b0, lvl(ch)};
    if (m == MODE_10) begin
      r = (r + 13'h2) >> 2;
      if (r > 13'h3ff) r = 13'h3ff;
    end else if (m == MODE_8) begin
      r = ((r >> 3) + 13'h1) >> 1;
      if (r > 13'h0ff) r = 13'h0ff;
    end
    return r[11:0];
  endfunction
  // Full conversion: start, wait for done, check results, flags and idle state.
  task automatic convert(input logic [4:0] ch, input adcc_mode_t m, input logic [1:0] cf,
                         input logic [11:0] cv, input logic hit);
    logic [11:0] e;
    int n;
    e = exp_res(ch, m);
    n = 0;
    wr(OFF_COMPARE, {20'h0, cv});
    wr(OFF_CFG, {28'h0, cf, m});
    wr(OFF_CTRL, {27'h0, ch});
    chk("analog_en", analog_en, 1'b1);
    chk("temp_sensor_en", temp_sensor_en, ch == TEMP_CH);
    chk("bandgap_en", bandgap_en, ch == BANDGAP_CH);
    do begin
      rdreg(OFF_STATUS);
      n++;
    end while (rd[ST_DONE_BIT] !== 1'b1 && n < 60);
    chk("done", rd[ST_DONE_BIT], 1'b1);
    chk("compare hit", rd[ST_CMP_BIT], hit);
    chk("busy", rd[ST_BUSY_BIT], 1'b0);
    chk("analog_en idle", analog_en, 1'b0);
    chk("sar_trial idle", sar_trial, 12'h000);
    rdreg(OFF_RES_HI);
    chk("result high", rd, {28'h0, e[11:8]});
    rdreg(OFF_RES_LO);
    chk("result low", rd, {24'h0, e[7:0]});
    wr(OFF_STATUS, 32'h3);
    rdreg(OFF_STATUS);
    chk("status cleared", rd, 32'h0);
  endtask
  // ------------------------------------------------------------
  // Test sequence.
  // ------------------------------------------------------------
  initial begin
    logic [7:0] offs[6];
    logic [31:0] rstv[6];
    logic [4:0] chs[11];
    adcc_mode_t mds[11];
    logic [1:0] cfs[11];
    logic [11:0] cvs[11];
    logic hits[11];
    int n;
    offs = '{OFF_CTRL, OFF_CFG, OFF_STATUS, OFF_MASK, OFF_COMPARE, OFF_PIN_DIS};
    rstv = '{32'h1f, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    // Internal channels are read in 12-bit mode; slow clock setup is software's job.
    chs = '{5'h03, 5'h0f, 5'h05, 5'h07, 5'h0f, TEMP_CH, BANDGAP_CH,
            5'h03, 5'h03, 5'h07, 5'h05};
    mds = '{MODE_12, MODE_10, MODE_10, MODE_8, MODE_8, MODE_12, MODE_12,
            MODE_12, MODE_12, MODE_8, MODE_10};
    cfs = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b11, 2'b01, 2'b11, 2'b01};
    cvs = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0,
            12'h300, 12'h300, 12'h050, 12'h050};
    hits = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 1, 0};
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    chk("analog_en in reset", analog_en, 1'b0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk("mux_sel off", mux_sel, CH_OFF);
    for (int i = 0; i < 6; i++) begin
      rdreg(offs[i]);
      chk("reset value", rd, rstv[i]);
    end
    rdreg(8'h20);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    // Upper pin control bits, each pattern then its complement.
    for (int i = 0; i < 2; i++) begin
      wr(OFF_PIN_DIS, (i == 0) ? 32'ha5 : 32'h5a);
      chk("pin_io_disable", pin_io_disable, (i == 0) ? 8'ha5 : 8'h5a);
      rdreg(OFF_PIN_DIS);
      chk("pin register", rd, (i == 0) ? 32'ha5 : 32'h5a);
    end
    for (int i = 0; i < 11; i++) begin
      convert(chs[i], mds[i], cfs[i], cvs[i], hits[i]);
    end
    // Interrupt raised, masked, unmasked and cleared.
    wr(OFF_MASK, 32'h1);
    wr(OFF_CTRL, 32'h2);
    chk("irq early", irq, 1'b0);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("irq raised", irq, 1'b1);
    wr(OFF_MASK, 32'h0);
    @(posedge clk);
    chk("irq masked", irq, 1'b0);
    wr(OFF_MASK, 32'h1);
    @(posedge clk);
    chk("irq unmasked", irq, 1'b1);
    wr(OFF_STATUS, 32'h3);
    @(posedge clk);
    chk("irq cleared", irq, 1'b0);
    // All-ones channel in mid-conversion switches the converter off with no done.
    wr(OFF_CTRL, 32'h9);
    repeat (5) @(posedge clk);
    wr(OFF_CTRL, {27'h0, CH_OFF});
    chk("analog_en off", analog_en, 1'b0);
    repeat (60) @(posedge clk);
    rdreg(OFF_STATUS);
    chk("no done when off", rd, 32'h0);
    chk("no irq when off", irq, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
